/* File: rtl/spi_format_ctrl.sv */
// serial port core: control register, word formats, clock phases, axi4-lite slave
//
// Function
// R1 - audio, both selects: 24-bit data, 32-bit channels
// R2 - audio, wide only: 32-bit data and channels
// R3 - audio, no selects: 16-bit data and channels
// R4 - plain mode: wide gives 32, none gives 8
// R5 - master samples at middle or end, selectable
// R6 - slave always samples at bit middle
// R7 - sample-phase set needs master already written
// R8 - edge bit picks which clock transition shifts
// R9 - slave select pin used only when enabled
// R10 - polarity bit sets clock idle level
// R11 - software avoids access right after disabling
// R12 - deep buffer bit writable only when off
// R13 - framed operation ignores the clock edge bit
// R14 - audio operation forces idle-high clock polarity
// R15 - deep buffer bit switches deep buffer operation; code only copies it to deep_buffer_active, buffers stay one word
`timescale 1ns/1ns
module spi_format_ctrl
	import spi_cfg_pkg::*;
#(
	parameter int DIV_W = 16
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	// axi4-lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// axi4-lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read address
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	// axi4-lite read data
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// serial clock pin
	input  wire logic        serial_clock_in,
	output logic             serial_clock_out,
	output logic             serial_clock_oe,
	// serial data pins
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_oe,
	// slave select pin, active low
	input  wire logic        slave_select_pin_n,
	// mode status
	output logic             slave_select_in_use,
	output logic             deep_buffer_active
);
	if (DIV_W < 1 || DIV_W > 16) begin : g_chk
		$error("spi_format_ctrl divisor width must be 1..16");
	end

	// registers
	logic [31:0]      ctrl_q;         // control word
	logic [DIV_W-1:0] div_q;          // half bit divisor
	logic [31:0]      txd_q;          // word waiting to go out
	logic [31:0]      rxd_q;          // last received word
	logic             tx_pending_q;   // txd_q not yet loaded
	logic             rx_full_q;      // rxd_q not yet read
	logic [31:0]      tx_q;           // outgoing shifter
	logic [31:0]      rx_q;           // incoming shifter
	logic [5:0]       samp_cnt_q;     // bits sampled in this word
	logic [6:0]       edge_cnt_q;     // master clock transitions
	xfer_e            state_q;        // master sequencer
	logic             sclk_prev_q;    // last synced clock for edges
	logic             first_q;        // slave: first bit already presented
	logic [7:0]       aw_addr_q;      // held write address
	logic             aw_full_q;      // write address held
	logic [31:0]      w_data_q;       // held write data
	logic [3:0]       w_strb_q;       // held strobes
	logic             w_full_q;       // write data held

	// synchronised pins
	logic sclk_s;
	logic sdi_s;
	logic ss_n_s;

	pin_sync #(.W(3)) u_sync (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.pin_in       ({serial_clock_in, serial_data_in, slave_select_pin_n}),
		.pin_sync_out ({sclk_s, sdi_s, ss_n_s})
	);

	// control fields
	wire mod_on      = ctrl_q[MODULE_ON_BIT];
	wire master_role = ctrl_q[MASTER_ROLE_BIT];
	wire audio_en    = ctrl_q[AUDIO_PROTOCOL_BIT];
	wire wide_sel    = ctrl_q[WIDE_WORD_BIT];
	wire half_sel    = ctrl_q[HALF_WORD_BIT];
	wire ss_use      = ctrl_q[SLAVE_SELECT_USE_BIT];
	wire framed_en   = ctrl_q[FRAMED_OPERATION_BIT];

	// effective clocking
	wire eff_pol     = audio_en | ctrl_q[CLOCK_IDLE_POL_BIT]; // R14 R10
	wire eff_edge    = framed_en ? 1'b0 : ctrl_q[CLOCK_EDGE_BIT]; // R13
	// edge=1: shift on active-to-idle, first bit shown before clocking
	wire shift_trail = eff_edge; // R8
	wire samp_end    = master_role & ctrl_q[SAMPLE_PHASE_BIT]; // R5 R6

	// word layout
	wire [5:0] n_chan = chan_bits(audio_en, wide_sel, half_sel); // R1 R2 R3 R4
	wire [5:0] n_data = data_bits(audio_en, wide_sel, half_sel); // R1 R2 R3 R4
	wire [5:0] n_pad  = n_chan - n_data; // 8 only for 24-in-32
	wire [5:0] n_lead = BITS_32 - n_data; // left-justify outgoing data
	wire [31:0] load_val = txd_q << n_lead;
	wire [31:0] rx_in    = {rx_q[30:0], sdi_s};
	wire [31:0] rx_word  = rx_in >> n_pad; // drop padding of 24-bit data
	wire [6:0]  two_n    = {n_chan, 1'b0};
	wire [6:0]  last_e   = (!shift_trail && samp_end) ? two_n + 7'h01 : two_n;

	// master sequencing on half bit ticks
	logic tick;
	wire  m_run  = (state_q == XFER_RUN);
	half_bit_tick #(.DIV_W(DIV_W)) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (m_run),
		.divisor (div_q),
		.tick    (tick)
	);
	wire [6:0] e_next   = edge_cnt_q + 7'h01;
	wire       m_start  = !m_run && mod_on && master_role && tx_pending_q;
	wire       m_step   = m_run && tick;
	wire       m_toggle = m_step && (e_next <= two_n);
	// change edges: even ones before the last, or odd ones after the first
	wire       m_shift  = m_step && (shift_trail ? (!e_next[0] && e_next < two_n)
	                                              : (e_next[0] && e_next > 7'h01)); // R8
	// middle sampling is the opposite edge; end sampling one half bit later
	wire       m_samp   = m_step && (e_next[0] == (shift_trail ^ samp_end))
	                      && !(e_next == 7'h01 && !shift_trail); // R5
	wire       m_last   = m_step && (e_next == last_e);

	// slave edge finding on the synced clock
	wire s_rise    = sclk_s & ~sclk_prev_q;
	wire s_fall    = ~sclk_s & sclk_prev_q;
	wire s_lead    = eff_pol ? s_fall : s_rise; // R10 R14
	wire s_trail   = eff_pol ? s_rise : s_fall;
	wire s_sel     = !ss_use || !ss_n_s; // R9
	wire s_active  = mod_on && !master_role && s_sel;
	// slave always samples mid-bit: opposite the shifting transition
	wire s_samp    = s_active && (shift_trail ? s_lead : s_trail); // R6 R8
	wire s_shift   = s_active && (shift_trail ? s_trail : (s_lead && !first_q)); // R8

	// shared shifter control
	wire do_samp   = m_samp | s_samp;
	wire do_shift  = m_shift | s_shift;
	wire word_done = do_samp && (samp_cnt_q == n_chan - 6'h01);
	wire s_reload  = !master_role && (!s_active || word_done);
	wire do_load   = m_start | s_reload;
	wire consume   = m_start | (!master_role && s_active && word_done);
	wire [31:0] tx_d = do_load ? load_val : (do_shift ? {tx_q[30:0], 1'b0} : tx_q);

	// axi decode
	wire aw_hs   = awvalid & awready;
	wire w_hs    = wvalid & wready;
	wire ar_hs   = arvalid & arready;
	wire wr_go   = aw_full_q && w_full_q && !bvalid;
	wire wr_ctrl = wr_go && (aw_addr_q == CTRL_OFS);
	wire wr_txd  = wr_go && (aw_addr_q == TXD_OFS);
	wire wr_div  = wr_go && (aw_addr_q == DIV_OFS);
	wire wr_ok   = wr_ctrl | wr_txd | wr_div | (wr_go && aw_addr_q == STAT_OFS)
	               | (wr_go && aw_addr_q == RXD_OFS);
	wire rd_rxd  = ar_hs && (araddr == RXD_OFS);
	wire rd_map  = (araddr == CTRL_OFS) || (araddr == STAT_OFS) || (araddr == TXD_OFS)
	               || rd_rxd || (araddr == DIV_OFS);

	// control write with its restrictions
	wire [31:0] ctrl_new = strb_merge(ctrl_q, w_data_q, w_strb_q) & CTRL_MASK;
	// a one needs the master bit already stored
	wire smp_ok = ctrl_new[SAMPLE_PHASE_BIT] & master_role; // R7
	// deep buffer bit frozen while the module runs
	wire deep_d = mod_on ? ctrl_q[DEEP_BUFFER_BIT] : ctrl_new[DEEP_BUFFER_BIT]; // R12
	wire [31:0] ctrl_d = {ctrl_new[31:17], deep_d, ctrl_new[15:10], smp_ok,
	                      ctrl_new[8:0]};
	wire [31:0] div_new = strb_merge({{(32-DIV_W){1'b0}}, div_q}, w_data_q, w_strb_q);

	// status word: widths and transfer state
	wire [31:0] stat_w = {2'h0, (audio_en ? two_n : {1'b0, n_chan}), 1'b0,
	                      n_data, 2'h0, n_chan, 4'h0, m_run,
	                      rx_full_q, tx_pending_q, mod_on};
	wire [31:0] rd_val = (araddr == CTRL_OFS) ? ctrl_q :
	                     (araddr == STAT_OFS) ? stat_w :
	                     (araddr == RXD_OFS)  ? rxd_q :
	                     (araddr == DIV_OFS)  ? {{(32-DIV_W){1'b0}}, div_q} : 32'h0;

	// control and divisor registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
			div_q  <= DIV_W'(DIV_RESET);
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= ctrl_d;
			end
			if (wr_div) begin
				div_q <= div_new[DIV_W-1:0];
			end
		end
	end

	// transmit holding word; a new write beats a same-cycle load
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txd_q        <= 32'h0;
			tx_pending_q <= 1'b0;
		end else if (wr_txd) begin
			txd_q        <= strb_merge(txd_q, w_data_q, w_strb_q);
			tx_pending_q <= 1'b1;
		end else if (consume) begin
			tx_pending_q <= 1'b0;
		end
	end

	// receive word; a finishing word wins over a same-cycle read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxd_q     <= 32'h0;
			rx_full_q <= 1'b0;
		end else if (word_done) begin
			rxd_q     <= rx_word;
			rx_full_q <= 1'b1;
		end else if (rd_rxd) begin
			rx_full_q <= 1'b0;
		end
	end

	// shifters and bit counter shared by both roles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_q       <= 32'h0;
			rx_q       <= 32'h0;
			samp_cnt_q <= 6'h00;
		end else begin
			tx_q <= tx_d;
			if (do_load) begin
				rx_q       <= 32'h0;
				samp_cnt_q <= 6'h00;
			end else if (do_samp) begin
				rx_q       <= rx_in;
				samp_cnt_q <= samp_cnt_q + 6'h01;
			end
		end
	end

	// master sequencer: one word per start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q    <= XFER_IDLE;
			edge_cnt_q <= 7'h00;
		end else begin
			case (state_q)
				XFER_IDLE: begin
					edge_cnt_q <= 7'h00;
					if (m_start) begin
						state_q <= XFER_RUN;
					end
				end
				XFER_RUN: begin
					// switching the module off aborts the word
					if (!mod_on || m_last) begin
						state_q <= XFER_IDLE;
					end else if (m_step) begin
						edge_cnt_q <= e_next;
					end
				end
				default: state_q <= XFER_IDLE;
			endcase
		end
	end

	// slave edge history and first-bit marker
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_prev_q <= 1'b0;
			first_q     <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
			if (s_reload) begin
				first_q <= 1'b1;
			end else if (s_lead && s_active) begin
				first_q <= 1'b0;
			end
		end
	end

	// pin drivers, all registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_clock_out    <= 1'b0;
			serial_clock_oe     <= 1'b0;
			serial_data_out     <= 1'b0;
			serial_data_oe      <= 1'b0;
			slave_select_in_use <= 1'b0;
			deep_buffer_active  <= 1'b0;
		end else begin
			// idle level follows polarity outside a word
			if (!m_run) begin
				serial_clock_out <= eff_pol; // R10 R14
			end else if (m_toggle) begin
				serial_clock_out <= ~serial_clock_out;
			end
			serial_clock_oe     <= mod_on & master_role;
			serial_data_out     <= tx_d[31];
			serial_data_oe      <= mod_on & (master_role | s_sel); // R9
			slave_select_in_use <= mod_on & !master_role & ss_use; // R9
			deep_buffer_active  <= ctrl_q[DEEP_BUFFER_BIT]; // R15
		end
	end

	// axi write channels: hold address and data, answer when both held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0;
			w_strb_q  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_addr_q <= {awaddr[7:2], 2'h0};
				aw_full_q <= 1'b1;
				awready   <= 1'b0;
			end
			if (w_hs) begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
				w_full_q <= 1'b1;
				wready   <= 1'b0;
			end
			if (wr_go) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// axi read channel: one read at a time, data one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= RESP_OKAY;
		end else if (ar_hs) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_val;
			rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end
endmodule : spi_format_ctrl

/* File: rtl/spi_cfg_pkg.sv */
// shared register map, field positions, reset values and word-layout helpers
package spi_cfg_pkg;
	// register byte offsets
	localparam logic [7:0]  CTRL_OFS   = 8'h00; // control word
	localparam logic [7:0]  STAT_OFS   = 8'h04; // status, read only
	localparam logic [7:0]  TXD_OFS    = 8'h08; // transmit word, write only
	localparam logic [7:0]  RXD_OFS    = 8'h0c; // receive word, read only
	localparam logic [7:0]  DIV_OFS    = 8'h10; // half bit time divisor
	// control field positions
	localparam int unsigned SLAVE_SELECT_USE_BIT  = 7;
	localparam int unsigned CLOCK_IDLE_POL_BIT    = 6;
	localparam int unsigned MASTER_ROLE_BIT       = 5;
	localparam int unsigned CLOCK_EDGE_BIT        = 8;
	localparam int unsigned SAMPLE_PHASE_BIT      = 9;
	localparam int unsigned HALF_WORD_BIT         = 10;
	localparam int unsigned WIDE_WORD_BIT         = 11;
	localparam int unsigned MODULE_ON_BIT         = 15;
	localparam int unsigned DEEP_BUFFER_BIT       = 16;
	localparam int unsigned AUDIO_PROTOCOL_BIT    = 23;
	localparam int unsigned FRAMED_OPERATION_BIT  = 31;
	// writable control bits
	localparam logic [31:0] CTRL_MASK  = 32'h8081_8fe0;
	// reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] DIV_RESET  = 16'h0004;
	// bit counts
	localparam logic [5:0]  BITS_8     = 6'h08;
	localparam logic [5:0]  BITS_16    = 6'h10;
	localparam logic [5:0]  BITS_24    = 6'h18;
	localparam logic [5:0]  BITS_32    = 6'h20;
	// axi response codes
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic {XFER_IDLE, XFER_RUN} xfer_e;

	// bits clocked per word (channel width in audio operation)
	function automatic logic [5:0] chan_bits(input logic aud, input logic wide,
		input logic half);
		if (aud) begin
			chan_bits = wide ? BITS_32 : BITS_16;
		end else if (wide) begin
			chan_bits = BITS_32;
		end else begin
			chan_bits = half ? BITS_16 : BITS_8;
		end
	endfunction : chan_bits

	// meaningful data bits inside a channel
	function automatic logic [5:0] data_bits(input logic aud, input logic wide,
		input logic half);
		if (aud && wide && half) begin
			data_bits = BITS_24;
		end else begin
			data_bits = chan_bits(aud, wide, half);
		end
	endfunction : data_bits

	// apply axi write strobes to an old word
	function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			strb_merge[i*8 +: 8] = strb[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
		end
	endfunction : strb_merge
endpackage : spi_cfg_pkg

/* File: rtl/pin_sync.sv */
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 3
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// raw pins and synchronised copies
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync_out
);
	logic [W-1:0] meta_q; // first stage, read only by the second

	if (W < 1) begin : g_chk
		$error("pin_sync needs at least one bit");
	end

	// two stages; the first is never looked at by any other logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q       <= '0;
			pin_sync_out <= '0;
		end else begin
			meta_q       <= pin_in;
			pin_sync_out <= meta_q;
		end
	end
endmodule : pin_sync

/* File: rtl/half_bit_tick.sv */
// divider giving a one-cycle pulse every half serial bit time
`timescale 1ns/1ns
module half_bit_tick #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// control
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] divisor,
	// pulse out
	output logic                  tick
);
	logic [DIV_W-1:0] cnt_q; // cycles since last pulse

	if (DIV_W < 1 || DIV_W > 16) begin : g_chk
		$error("half_bit_tick divisor width must be 1..16");
	end

	// period is divisor+1 cycles; restarts whenever run drops
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (cnt_q >= divisor) begin
			cnt_q <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule : half_bit_tick

/* File: test/spi_format_ctrl_monitor.sv */
// checker for the bus handshakes and the mode pins of the serial port core
`timescale 1ns/1ns
module spi_format_ctrl_monitor
	import spi_cfg_pkg::*;
(
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        awready,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	// pins and mode status
	input wire logic        serial_clock_oe,
	input wire logic        serial_data_oe,
	input wire logic        slave_select_pin_n,
	input wire logic        slave_select_in_use,
	input wire logic        deep_buffer_active
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
	property p_r_lat; arvalid && arready |=> rvalid; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_b_block; bvalid |-> !awready && !wready; endproperty
	a_b_block: assert property (p_b_block) else $error("new write taken too early");
	property p_resp; bvalid |-> bresp == RESP_OKAY || bresp == RESP_SLVERR; endproperty
	a_resp: assert property (p_resp) else $error("bad write response code");
	// a slave never drives the clock pin
	property p_slave_clk; slave_select_in_use |-> !serial_clock_oe; endproperty
	a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");
	// deselected slave lets go of the data pin after the sync delay
	property p_ss_off; (slave_select_in_use && slave_select_pin_n) [*5] |-> !serial_data_oe;
	endproperty
	a_ss_off: assert property (p_ss_off) else $error("deselected slave drives data");
	// the deep buffer flag moves only with a completed write
	property p_deep; $changed(deep_buffer_active) |-> $past(bvalid); endproperty
	a_deep: assert property (p_deep) else $error("deep buffer changed alone");
	c_write: cover property (bvalid && bready);
	c_slave: cover property (slave_select_in_use && !slave_select_pin_n);
	c_deep: cover property ($rose(deep_buffer_active));
endmodule : spi_format_ctrl_monitor

bind spi_format_ctrl spi_format_ctrl_monitor mon_u (.aclk, .aresetn, .awready, .wready,
	.bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
	.serial_clock_oe, .serial_data_oe, .slave_select_pin_n, .slave_select_in_use,
	.deep_buffer_active);

/* File: test/spi_link_partner.sv */
// far-side slave device: shifts its word out and gathers the word shifted in
`timescale 1ns/1ns
module spi_link_partner (
	// clock
	input  wire logic        aclk,
	// serial pins
	input  wire logic        sclk,
	input  wire logic        mosi,
	output logic             miso,
	// mode and word set by the bench
	input  wire logic        pol,
	input  wire logic        edge_mode,
	input  wire logic        load,
	input  wire logic [31:0] tx_word,
	input  wire logic [5:0]  nbits,
	output logic [31:0]      rx_word
);
	logic        sclk_q; // last clock level seen
	logic [31:0] sh_q;   // outgoing word, left aligned
	logic [5:0]  tcnt_q; // trailing edges so far
	wire  logic  chg   = sclk != sclk_q;
	wire  logic  lead  = chg && (sclk != pol);
	wire  logic  trail = chg && (sclk == pol);
	// shift on one transition, sample on the other
	always_ff @(posedge aclk) begin
		sclk_q <= sclk;
		if (load) begin
			sh_q    <= tx_word << (6'd32 - nbits);
			tcnt_q  <= '0;
			rx_word <= '0;
			// wrong level until the first leading edge when shifting on leading
			miso    <= edge_mode ? tx_word[nbits-1] : !tx_word[nbits-1];
		end else begin
			if (edge_mode ? lead : trail) begin
				rx_word <= {rx_word[30:0], mosi};
			end
			if (trail) begin
				tcnt_q <= tcnt_q + 6'd1;
			end
			if (tcnt_q == nbits) begin
				miso <= !miso; // frame over, line carries no data
			end else if (edge_mode ? trail : lead) begin
				miso <= edge_mode ? sh_q[30] : sh_q[31];
				sh_q <= sh_q << 1;
			end
		end
	end
endmodule : spi_link_partner

/* File: test/spi_format_and_clocking_control_tb.sv */
// self-checking bench: registers, word formats, clock modes, master and slave roles
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module spi_format_and_clocking_control_tb
	import spi_cfg_pkg::*;
;
	logic        aclk = 0, aresetn = 0;           // clock, reset
	logic [7:0]  awaddr = 0, araddr = 0;          // bus addresses
	logic        awvalid = 0, wvalid = 0, arvalid = 0;
	logic        bready = 1, rready = 1;          // answers always welcome
	logic [31:0] wdata = 0, rd;
	logic [3:0]  wstrb = 4'hf;
	logic [1:0]  rs;
	wire  logic  awready, wready, bvalid, arready, rvalid;
	wire  logic [1:0]  bresp, rresp;
	wire  logic [31:0] rdata, prx;
	logic        serial_clock_in = 0, slave_select_pin_n = 1; // bench as master
	logic        mosi_m = 0, tgl = 0, smode = 1;
	logic        pol_m = 0, edge_m = 1, load_m = 0;  // partner mode
	logic [31:0] txw = 0;
	logic [5:0]  nb = 6'h08;
	logic [15:0] lf = 16'h416f;                   // random source
	wire  logic  serial_clock_out, serial_clock_oe, serial_data_out, serial_data_oe;
	wire  logic  slave_select_in_use, deep_buffer_active, miso;
	// idle data line keeps changing so a stale level is never read as data
	wire  logic  serial_data_in = smode ? (slave_select_pin_n ? tgl : mosi_m) : miso;
	int          failures = 0, n_tests = 0, cyc = 0;
	localparam logic [4:0] MODES [6] = '{5'h04, 5'h08, 5'h07, 5'h0e, 5'h01, 5'h1e};

	spi_format_ctrl #(.DIV_W(16)) dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .serial_clock_in, .serial_clock_out,
		.serial_clock_oe, .serial_data_in, .serial_data_out, .serial_data_oe,
		.slave_select_pin_n, .slave_select_in_use, .deep_buffer_active);
	spi_link_partner peer_u (.aclk, .sclk(serial_clock_out), .mosi(serial_data_out),
		.miso, .pol(pol_m), .edge_mode(edge_m), .load(load_m), .tx_word(txw), .nbits(nb),
		.rx_word(prx));

	// clock, idle toggle and hang guard
	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		tgl <= ~tgl;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// expected channel, data and frame bit counts in the status word
	function automatic logic [31:0] exp_stat(input int i);
		logic [6:0] ch, dt;
		ch = (i[2] || !i[1]) ? (i[1] ? 7'd32 : (i[0] ? 7'd16 : (i[2] ? 7'd16 : 7'd8))) : 7'd32;
		dt = (i[2] && i[1] && i[0]) ? 7'd24 : ch;
		exp_stat = {2'b0, (i[2] ? ch << 1 : ch), 1'b0, dt[5:0], 2'b0, ch[5:0], 8'h0};
	endfunction : exp_stat
	// one write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
		end while (!bvalid);
		`CHK("bresp", er, bresp)
		@(posedge aclk); // registered mode pins lag the stored word
	endtask : wr
	task automatic rd_t(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
	endtask : rd_t
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd_t(a, rd, rs);
		`CHK("rdata", e, rd & m)
	endtask : chk_rd
	task automatic end_of_test();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test

	// main sequence
	initial begin
		logic [4:0] m;
		logic [31:0] dw, mk, sh;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		chk_rd(CTRL_OFS, 32'hffff_ffff, CTRL_RESET);
		chk_rd(DIV_OFS, 32'h0000_ffff, {16'h0, DIV_RESET});
		rd_t(8'h14, rd, rs);
		`CHK("unmapped", RESP_SLVERR, rs)
		wr(8'h14, 32'hffff_ffff, RESP_SLVERR);
		wr(DIV_OFS, 32'h0000_0003, RESP_OKAY); // four cycles a half bit
		for (int i = 0; i < 8; i++) begin
			wr(CTRL_OFS, (32'(i[2]) << 23) | (32'(i[1]) << 11) | (32'(i[0]) << 10), RESP_OKAY);
			chk_rd(STAT_OFS, 32'h3fbf_3f00, exp_stat(i));
		end
		for (int i = 0; i < 4; i++) begin
			wr(CTRL_OFS, 32'h8020 | (32'(i[0]) << 6) | (32'(i[1]) << 23), RESP_OKAY);
			repeat (4) @(posedge aclk);
			`CHK("idle level", 1'(i[0] | i[1]), serial_clock_out)
		end
		// sample phase needs the master bit stored first
		wr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
		repeat (2) @(posedge aclk);
		wr(CTRL_OFS, 32'h0000_0220, RESP_OKAY);
		chk_rd(CTRL_OFS, 32'h0000_0220, 32'h0000_0020);
		wr(CTRL_OFS, 32'h0000_0220, RESP_OKAY);
		chk_rd(CTRL_OFS, 32'h0000_0220, 32'h0000_0220);
		// deep buffer bit only moves while off
		wr(CTRL_OFS, 32'h0000_8000, RESP_OKAY);
		wr(CTRL_OFS, 32'h0001_8000, RESP_OKAY);
		`CHK("deep while on", 1'b0, deep_buffer_active)
		wr(CTRL_OFS, 32'h0001_0000, RESP_OKAY);
		wr(CTRL_OFS, 32'h0001_0000, RESP_OKAY);
		`CHK("deep on", 1'b1, deep_buffer_active)
		wr(CTRL_OFS, 32'h0001_8020, RESP_OKAY);
		wr(CTRL_OFS, 32'h0000_8220, RESP_OKAY);
		`CHK("deep kept", 1'b1, deep_buffer_active)
		chk_rd(CTRL_OFS, 32'h0001_0200, 32'h0001_0200);
		wr(CTRL_OFS, 32'h0000_0020, RESP_OKAY);
		wr(CTRL_OFS, 32'h0000_0020, RESP_OKAY);
		`CHK("deep off", 1'b0, deep_buffer_active)
		// slave role, sample phase left set, bench clocks a byte in
		wr(CTRL_OFS, 32'h0000_8380, RESP_OKAY);
		`CHK("ss in use", 1'b1, slave_select_in_use)
		lf = lfsr(lf);
		sh = {lf[7:0], 24'h0};
		slave_select_pin_n <= 0;
		mosi_m <= sh[31];
		repeat (4) @(posedge aclk);
		repeat (8) begin
			serial_clock_in <= 1;
			repeat (4) @(posedge aclk);
			sh = sh << 1;
			serial_clock_in <= 0;
			mosi_m <= sh[31];
			repeat (4) @(posedge aclk);
		end
		slave_select_pin_n <= 1;
		repeat (6) @(posedge aclk);
		chk_rd(RXD_OFS, 32'h0000_00ff, {24'h0, lf[7:0]});
		// master role over the clock modes, with the partner answering
		smode <= 0;
		for (int j = 0; j < 6; j++) begin
			m = MODES[j];
			lf = lfsr(lf);
			dw = {lf, lfsr(lf)};
			lf = lfsr(lfsr(lf));
			mk = m[0] ? 32'hffff_ffff : 32'h0000_00ff;
			wr(CTRL_OFS, 32'h0000_0020, RESP_OKAY);
			repeat (2) @(posedge aclk);
			wr(CTRL_OFS, 32'h8020 | (32'(m[3]) << 6) | (32'(m[2]) << 8) | (32'(m[1]) << 9) |
				(32'(m[0]) << 11) | (32'(m[4]) << 31), RESP_OKAY);
			pol_m <= m[3];
			edge_m <= m[2] & !m[4];
			nb <= m[0] ? 6'h20 : 6'h08;
			txw <= {lf, dw[15:0]};
			load_m <= 1;
			@(posedge aclk);
			load_m <= 0;
			wr(TXD_OFS, dw, RESP_OKAY);
			do rd_t(STAT_OFS, rd, rs); while (rd[2] !== 1'b1);
			chk_rd(RXD_OFS, mk, {lf, dw[15:0]} & mk);
			`CHK("peer rx", dw & mk, prx)
		end
		end_of_test();
	end
endmodule : spi_format_and_clocking_control_tb
